/* sit_pkg.sv */
// shared constants and types of the scheduled interval timer
package sit_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// clock and time units
	localparam int unsigned CLK_FREQ_HZ = 100_000_000;
	localparam int unsigned CYC_PER_US = CLK_FREQ_HZ / 1_000_000;
	localparam int unsigned UNIT_10MS_US = 10_000;
	localparam int unsigned UNIT_1MS_US = 1_000;
	localparam int unsigned UNIT_0P1MS_US = 100;
	localparam int unsigned UNIT_10MS_CYC = UNIT_10MS_US * CYC_PER_US;
	localparam int unsigned UNIT_1MS_CYC = UNIT_1MS_US * CYC_PER_US;
	localparam int unsigned UNIT_0P1MS_CYC = UNIT_0P1MS_US * CYC_PER_US;
	localparam int unsigned PRE_W = 20;

	////////////////////////////////////////////////////////////////////////////////
	// register map (byte addresses)
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned SETUP_IDX = 195;
	localparam logic [ADDR_W-1:0] ADDR_SETUP = 12'(4 * SETUP_IDX);
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_INTV = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_START = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_MASK = 12'h00c;
	localparam logic [ADDR_W-1:0] ADDR_CLRCNT = 12'h010;
	localparam logic [ADDR_W-1:0] ADDR_RDSEL = 12'h014;
	localparam logic [ADDR_W-1:0] ADDR_RDDATA = 12'h018;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 12'h01c;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR = 12'h020;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 12'h024;
	localparam logic [ADDR_W-1:0] ADDR_STATE = 12'h028;

	////////////////////////////////////////////////////////////////////////////////
	// fields and reset values
	localparam int unsigned UNIT_W = 4;
	localparam logic [UNIT_W-1:0] UNIT_RST = 4'h0;
	localparam logic [UNIT_W-1:0] UNIT_10MS = 4'h0;
	localparam logic [UNIT_W-1:0] UNIT_1MS = 4'h1;
	localparam logic [UNIT_W-1:0] UNIT_0P1MS = 4'h2;
	localparam int unsigned CTRL_RUN_BIT = 0;
	localparam int unsigned INTV_W = 16;
	localparam logic [INTV_W-1:0] INTV_RST = 16'h0000;
	localparam logic [INTV_W-1:0] INTV_MAX_0P1MS = 16'h270f;
	localparam int unsigned INTV_MIN_0P1MS = 2;
	localparam int unsigned STAT_W = 3;
	localparam int unsigned STAT_CH0 = 0;
	localparam int unsigned STAT_CH1 = 1;
	localparam int unsigned STAT_REFUSED = 2;
	localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
	localparam int unsigned STATE_CHRUN_LSB = 1;
	localparam int unsigned STATE_UNIT_LSB = 4;
	localparam int unsigned NUM_CH = 2;

	////////////////////////////////////////////////////////////////////////////////
	// channel codes for start, mask, clear and read-back
	localparam logic [7:0] CODE_CH0_NORM = 8'h04;
	localparam logic [7:0] CODE_CH1_NORM = 8'h05;
	localparam logic [7:0] CODE_CH0_RST = 8'h0e;
	localparam logic [7:0] CODE_CH1_RST = 8'h0f;

	typedef enum logic {BUS_IDLE, BUS_ACK} sit_bus_st_t;

endpackage

/* sit_tick_gen.sv */
// per-channel tick prescaler for the scheduled interval timer
module sit_tick_gen #(
	parameter int unsigned P_CYC_10MS = sit_pkg::UNIT_10MS_CYC,
	parameter int unsigned P_CYC_1MS = sit_pkg::UNIT_1MS_CYC,
	parameter int unsigned P_CYC_0P1MS = sit_pkg::UNIT_0P1MS_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_run,
	input wire logic i_restart,
	input wire logic [sit_pkg::UNIT_W-1:0] i_unit,
	output logic o_tick
);
	import sit_pkg::*;

	logic [PRE_W-1:0] pre_r;
	logic [PRE_W-1:0] last_w;

	// last count of one tick period; unknown codes fall back to the slowest unit
	function automatic logic [PRE_W-1:0] tick_last(input logic [UNIT_W-1:0] u);
		case (u)
			UNIT_1MS: tick_last = PRE_W'(P_CYC_1MS - 1);
			UNIT_0P1MS: tick_last = PRE_W'(P_CYC_0P1MS - 1);
			default: tick_last = PRE_W'(P_CYC_10MS - 1);
		endcase
	endfunction

	assign last_w = tick_last(i_unit);

	////////////////////////////////////////////////////////////////////////////////
	// prescaler; restart realigns the phase so the first tick is a full unit away
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn || i_restart || !i_run) begin
			pre_r <= '0;
		end else if (pre_r >= last_w) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + PRE_W'(1);
		end
	end

	// tick registered so the channel sees a clean one-cycle pulse
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_tick <= 1'b0;
		end else begin
			o_tick <= i_run && !i_restart && (pre_r >= last_w);
		end
	end

endmodule

/* sit_timer.sv */
// scheduled interval timer with two periodic channels and an avalon-mm register slave
// Notes on behaviour
// R1 - unit field: 0=10ms, 1=1ms, 2=0.1ms, default 0
// R2 - 0.1ms unit accepts intervals min to 999.9ms
// R3 - interval sets spacing between channel interrupts
// R4 - codes 4/5 start without clearing count
// R5 - codes 14/15 clear count, first interrupt one interval
// R6 - normal start delay fixed only after clear
// R7 - read codes 4/5 return programmed interval
// R8 - read codes 14/15 return elapsed count
// R9 - elapsed counted from start or last interrupt
// R10 - elapsed count in currently selected tick unit
// R11 - mask stops channel interrupts until restarted
// R12 - unit sampled only when operation starts
// R13 - count reaching interval raises interrupt, reloads zero
//
// Local design decisions: the address map and the Avalon-MM slave port.
module sit_timer #(
	parameter int unsigned P_CYC_10MS = sit_pkg::UNIT_10MS_CYC,
	parameter int unsigned P_CYC_1MS = sit_pkg::UNIT_1MS_CYC,
	parameter int unsigned P_CYC_0P1MS = sit_pkg::UNIT_0P1MS_CYC,
	parameter int unsigned P_INTV_MIN = sit_pkg::INTV_MIN_0P1MS
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic [sit_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_irq
);
	import sit_pkg::*;

	sit_bus_st_t bus_st_r;
	logic wr_fire;
	logic lane0;
	logic [UNIT_W-1:0] setup_unit_r;
	logic [UNIT_W-1:0] unit_lat_r;
	logic op_run_r;
	logic [INTV_W-1:0] intv_stage_r;
	logic [7:0] rdsel_r;
	logic [NUM_CH-1:0] run_ch_r;
	logic [NUM_CH-1:0][INTV_W-1:0] intv_r;
	logic [NUM_CH-1:0][INTV_W-1:0] cnt_r;
	logic [NUM_CH-1:0] tick_ch;
	logic [NUM_CH-1:0] restart_ch;
	logic [NUM_CH-1:0] start_ch;
	logic [NUM_CH-1:0] mask_ch;
	logic [NUM_CH-1:0] ev_ch;
	logic [2:0] start_dec;
	logic start_hit;
	logic start_ok;
	logic start_bad;
	logic op_begin;
	logic [STAT_W-1:0] stat_r;
	logic [STAT_W-1:0] stat_en_r;
	logic [STAT_W-1:0] stat_clr;
	logic [STAT_W-1:0] stat_set;
	logic [31:0] rd_mux;
	logic [31:0] be_mask;

	// {valid, reset start, channel} from a channel code
	function automatic logic [2:0] decode_code(input logic [7:0] c);
		case (c)
			CODE_CH0_NORM: decode_code = 3'b100;
			CODE_CH1_NORM: decode_code = 3'b101;
			CODE_CH0_RST: decode_code = 3'b110;
			CODE_CH1_RST: decode_code = 3'b111;
			default: decode_code = 3'b000;
		endcase
	endfunction

	// bit mask of the written lanes
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// bus slave: one wait cycle per access; writes land at the edge waitrequest is low
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			bus_st_r <= BUS_IDLE;
		end else begin
			case (bus_st_r)
				BUS_IDLE: begin
					if (i_avs_read || i_avs_write) begin
						bus_st_r <= BUS_ACK;
					end
				end
				BUS_ACK: bus_st_r <= BUS_IDLE;
				default: bus_st_r <= BUS_IDLE;
			endcase
		end
	end

	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && (bus_st_r != BUS_ACK);
	assign wr_fire = i_avs_write && (bus_st_r == BUS_ACK);
	assign lane0 = i_avs_byteenable[0];
	assign be_mask = lane_mask(i_avs_byteenable);

	// read mux; unmapped addresses read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (i_avs_address)
			ADDR_SETUP: rd_mux[UNIT_W-1:0] = setup_unit_r;
			ADDR_CTRL: rd_mux[CTRL_RUN_BIT] = op_run_r;
			ADDR_INTV: rd_mux[INTV_W-1:0] = intv_stage_r;
			ADDR_RDSEL: rd_mux[7:0] = rdsel_r;
			// R7 interval read-back
			// R8 elapsed count read-back, already in the latched unit
			// R10 unit follows latch
			ADDR_RDDATA: begin
				case (rdsel_r)
					CODE_CH0_NORM: rd_mux[INTV_W-1:0] = intv_r[0];
					CODE_CH1_NORM: rd_mux[INTV_W-1:0] = intv_r[1];
					CODE_CH0_RST: rd_mux[INTV_W-1:0] = cnt_r[0];
					CODE_CH1_RST: rd_mux[INTV_W-1:0] = cnt_r[1];
					default: rd_mux = 32'h0000_0000;
				endcase
			end
			ADDR_IRQ_STAT: rd_mux[STAT_W-1:0] = stat_r;
			ADDR_IRQ_EN: rd_mux[STAT_W-1:0] = stat_en_r;
			ADDR_STATE: begin
				rd_mux[0] = op_run_r;
				rd_mux[STATE_CHRUN_LSB +: NUM_CH] = run_ch_r;
				rd_mux[STATE_UNIT_LSB +: UNIT_W] = unit_lat_r;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data captured at the first edge of the request, one cycle before it is accepted, held through the answer
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (bus_st_r == BUS_IDLE && i_avs_read) begin
			o_avs_readdata <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// plain configuration registers
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			setup_unit_r <= UNIT_RST;
			intv_stage_r <= INTV_RST;
			rdsel_r <= 8'h00;
			stat_en_r <= STAT_RST;
		end else if (wr_fire && lane0) begin
			case (i_avs_address)
				// R1 unit select field
				ADDR_SETUP: setup_unit_r <= i_avs_writedata[UNIT_W-1:0];
				ADDR_RDSEL: rdsel_r <= i_avs_writedata[7:0];
				ADDR_IRQ_EN: stat_en_r <= i_avs_writedata[STAT_W-1:0];
				default: ;
			endcase
		end
		if (i_resetn && wr_fire && i_avs_address == ADDR_INTV) begin
			intv_stage_r <= (intv_stage_r & ~be_mask[INTV_W-1:0]) |
				(i_avs_writedata[INTV_W-1:0] & be_mask[INTV_W-1:0]);
		end
	end

	// R12 unit latched only on the stopped-to-running edge
	assign op_begin = wr_fire && lane0 && i_avs_address == ADDR_CTRL &&
		i_avs_writedata[CTRL_RUN_BIT] && !op_run_r;

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			op_run_r <= 1'b0;
			unit_lat_r <= UNIT_RST;
		end else begin
			if (wr_fire && lane0 && i_avs_address == ADDR_CTRL) begin
				op_run_r <= i_avs_writedata[CTRL_RUN_BIT];
			end
			if (op_begin) begin
				unit_lat_r <= setup_unit_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// command decode
	assign start_hit = wr_fire && lane0 && i_avs_address == ADDR_START;
	assign start_dec = decode_code(i_avs_writedata[7:0]);
	// R2 range check against the latched unit; zero is never a valid interval
	assign start_ok = (unit_lat_r == UNIT_0P1MS) ?
		(intv_stage_r >= INTV_W'(P_INTV_MIN) && intv_stage_r <= INTV_MAX_0P1MS) :
		(intv_stage_r != INTV_RST);
	assign start_bad = start_hit && start_dec[2] && !start_ok;

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			start_ch[c] = start_hit && start_dec[2] && start_ok && start_dec[0] == c[0];
			mask_ch[c] = wr_fire && lane0 && i_avs_address == ADDR_MASK &&
				decode_code(i_avs_writedata[7:0]) == {2'b10, c[0]};
			// R5 reset start restarts count and phase
			// R6 separate clear command fixes the first-interrupt delay
			restart_ch[c] = op_begin || (start_ch[c] && start_dec[1]) ||
				(wr_fire && lane0 && i_avs_address == ADDR_CLRCNT &&
				decode_code(i_avs_writedata[7:0]) == {2'b10, c[0]});
			// R13 interval reached; a mask in the same cycle suppresses it
			ev_ch[c] = tick_ch[c] && run_ch_r[c] && op_run_r && !restart_ch[c] && !mask_ch[c] &&
				({1'b0, cnt_r[c]} + 17'h1 >= {1'b0, intv_r[c]});
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// per-channel prescalers; the phase is shared with nothing so a reset start is exact
	for (genvar g = 0; g < NUM_CH; g++) begin : g_tick
		sit_tick_gen #(
			.P_CYC_10MS(P_CYC_10MS),
			.P_CYC_1MS(P_CYC_1MS),
			.P_CYC_0P1MS(P_CYC_0P1MS)
		) u_tick (
			.i_clk_sys(i_clk_sys),
			.i_resetn(i_resetn),
			.i_run(op_run_r && run_ch_r[g]),
			.i_restart(restart_ch[g]),
			.i_unit(unit_lat_r),
			.o_tick(tick_ch[g])
		);
	end

	// channel run, interval and elapsed count
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			run_ch_r <= '0;
			intv_r <= '0;
			cnt_r <= '0;
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				// R11 mask halts the channel until the next start
				if (mask_ch[c]) begin
					run_ch_r[c] <= 1'b0;
				end else if (start_ch[c]) begin
					run_ch_r[c] <= 1'b1;
				end
				// R3 interval loaded on an accepted start
				if (start_ch[c]) begin
					intv_r[c] <= intv_stage_r;
				end
				// R4 normal start leaves the count alone
				// R9 count runs from start or last interrupt
				if (restart_ch[c]) begin
					cnt_r[c] <= '0;
				end else if (ev_ch[c]) begin
					cnt_r[c] <= '0;
				end else if (tick_ch[c] && run_ch_r[c] && op_run_r && !mask_ch[c]) begin
					cnt_r[c] <= cnt_r[c] + INTV_W'(1);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sticky status; a new event beats a clear in the same cycle
	assign stat_clr = (wr_fire && lane0 && i_avs_address == ADDR_IRQ_CLR) ?
		i_avs_writedata[STAT_W-1:0] : STAT_RST;
	assign stat_set = {start_bad, ev_ch[1], ev_ch[0]};

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			stat_r <= STAT_RST;
		end else begin
			stat_r <= (stat_r & ~stat_clr) | stat_set;
		end
	end

	// level interrupt, registered to keep the output glitch free
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(stat_r & stat_en_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_reset_start0;
		start_ch[0] && start_dec[1];
	endsequence

	sequence s_norm_start0;
		start_ch[0] && !start_dec[1] && !tick_ch[0] && !restart_ch[0];
	endsequence

	sequence s_mask0;
		mask_ch[0] && !start_ch[0];
	endsequence

	AST_UNIT_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R12
		(op_run_r && !op_begin) |=> $stable(unit_lat_r))
		else $error("unit changed while running");

	AST_RESET_START: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R5
		s_reset_start0 |=> (cnt_r[0] == '0 && run_ch_r[0]))
		else $error("reset start did not clear count");

	AST_NORMAL_START: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R4
		s_norm_start0 |=> (cnt_r[0] == $past(cnt_r[0])))
		else $error("normal start changed count");

	AST_INTV_LOAD: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R3
		start_ch[1] |=> (intv_r[1] == $past(intv_stage_r)))
		else $error("interval not loaded");

	AST_RANGE: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R2
		(start_hit && start_dec[2] && unit_lat_r == UNIT_0P1MS && intv_stage_r < INTV_W'(P_INTV_MIN))
		|=> (stat_r[STAT_REFUSED] && intv_r == $past(intv_r)))
		else $error("short interval accepted");

	AST_WRAP: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R13
		ev_ch[0] |=> (cnt_r[0] == '0 && stat_r[STAT_CH0]) ##1 (o_irq || !$past(stat_en_r[STAT_CH0])))
		else $error("wrap did not raise event");

	AST_MASK: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R11
		s_mask0 ##1 !start_ch[0] |-> !ev_ch[0] && !run_ch_r[0])
		else $error("masked channel still fires");

	AST_READ_INTV: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R7
		(bus_st_r == BUS_IDLE && i_avs_read && i_avs_address == ADDR_RDDATA && rdsel_r == CODE_CH0_NORM)
		|=> (o_avs_readdata == {16'h0000, $past(intv_r[0])}) && !o_avs_waitrequest)
		else $error("interval read-back wrong");

	AST_READ_CNT: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R8
		(bus_st_r == BUS_IDLE && i_avs_read && i_avs_address == ADDR_RDDATA && rdsel_r == CODE_CH1_RST)
		|=> (o_avs_readdata == {16'h0000, $past(cnt_r[1])}))
		else $error("count read-back wrong");

endmodule

/* sit_timer_tb.sv */
// self-checking bench for the scheduled interval timer
module sit_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sit_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// shortened tick lengths keep the run to about fifteen hundred cycles
	localparam int unsigned C10 = 40;
	localparam int unsigned C1 = 20;
	localparam int unsigned C01 = 10;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [ADDR_W-1:0] address = '0;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] ben = 4'hf;
	logic [31:0] rdata;
	logic waitreq;
	logic irq;
	logic [31:0] q;
	int fails = 0;
	int checks = 0;
	int cyc = 0;

	sit_timer #(.P_CYC_10MS(C10), .P_CYC_1MS(C1), .P_CYC_0P1MS(C01), .P_INTV_MIN(2)) dut (
		.i_clk_sys(clk_sys),
		.i_resetn(resetn),
		.i_avs_address(address),
		.i_avs_read(rd_en),
		.i_avs_write(wr_en),
		.i_avs_writedata(wdata),
		.i_avs_byteenable(ben),
		.o_avs_readdata(rdata),
		.o_avs_waitrequest(waitreq),
		.o_irq(irq)
	);

	// free clock and a cycle stamp for interval measurements
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// report, compare and bus helpers
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask

	// request held until the edge that samples waitrequest low, released only then
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk_sys);
		address <= a;
		wdata <= d;
		wr_en <= w;
		rd_en <= ~w;
		do begin
			@(posedge clk_sys);
			n++;
		end while (waitreq !== 1'b0 && n < 100);
		r = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		if (n >= 100) begin
			fails++;
			$display("FAIL bus wait expected waitrequest 0 seen %b", waitreq);
			end_sim();
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, r);
	endtask

	task automatic rd_code(input logic [7:0] code, output logic [31:0] r);
		wr(ADDR_RDSEL, {24'h0, code});
		rd(ADDR_RDDATA, r);
	endtask

	task automatic start(input logic [7:0] code, input logic [15:0] intv);
		wr(ADDR_INTV, {16'h0, intv});
		wr(ADDR_START, {24'h0, code});
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// bounded wait for the interrupt line; a hang ends the run as a mismatch
	task automatic wait_irq(output int t);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		t = cyc;
		if (n >= 2000) begin
			fails++;
			$display("FAIL irq wait expected 1 seen %b", irq);
			end_sim();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		chk("irq after reset", 32'h0, {31'h0, irq});
		rd(ADDR_SETUP, q);
		chk("setup default", 32'h0, q);
		rd(ADDR_IRQ_STAT, q);
		chk("status default", 32'h0, q);
		wr(ADDR_SETUP, 32'h2);
		rd(ADDR_SETUP, q);
		chk("setup readback", 32'h2, q);
		wr(12'h100, 32'h5a);
		rd(12'h100, q);
		chk("unmapped read", 32'h0, q);
		wr(ADDR_IRQ_EN, 32'h7);
		rd(ADDR_IRQ_EN, q);
		chk("enable readback", 32'h7, q);
		rd(ADDR_IRQ_CLR, q);
		chk("clear reads zero", 32'h0, q);
		$display("t_reset done");
	endtask

	// each unit latched at run start, elapsed count read in that unit
	task automatic t_units();
		int cycs[3] = '{C10, C1, C01};
		int e;
		for (int u = 0; u < 3; u++) begin
			wr(ADDR_SETUP, u);
			wr(ADDR_CTRL, 32'h0);
			wr(ADDR_CTRL, 32'h1);
			rd(ADDR_STATE, q);
			chk("latched unit", u, {28'h0, q[7:4]});
			start(CODE_CH0_RST, 16'd1000);
			idle(200);
			rd_code(CODE_CH0_RST, q);
			e = 200 / cycs[u];
			chk("elapsed in unit", 32'h1, {31'h0, q >= e - 1 && q <= e + 1});
		end
		// field change without a run restart must not retime the channel
		wr(ADDR_SETUP, 32'h0);
		start(CODE_CH0_RST, 16'd1000);
		idle(200);
		rd_code(CODE_CH0_RST, q);
		chk("unit kept count", 32'h1, {31'h0, q >= 19 && q <= 21});
		rd(ADDR_STATE, q);
		chk("unit kept state", 32'h2, {28'h0, q[7:4]});
		$display("t_units done");
	endtask

	task automatic t_period();
		int t0;
		int t1;
		int t2;
		wr(ADDR_IRQ_CLR, 32'h7);
		wr(ADDR_IRQ_EN, 32'h1);
		wr(ADDR_INTV, 32'h3);
		t0 = cyc;
		wr(ADDR_START, {24'h0, CODE_CH0_RST});
		wait_irq(t1);
		chk("first irq delay", 32'h1, {31'h0, t1 - t0 >= 30 && t1 - t0 <= 36});
		rd_code(CODE_CH0_RST, q);
		chk("count after irq", 32'h1, {31'h0, q <= 1});
		wr(ADDR_IRQ_CLR, 32'h1);
		idle(3);
		wait_irq(t2);
		chk("irq spacing", 32'd30, t2 - t1);
		$display("t_period done");
	endtask

	task automatic t_mask();
		int t;
		wr(ADDR_MASK, {24'h0, CODE_CH0_NORM});
		wr(ADDR_IRQ_CLR, 32'h1);
		idle(100);
		rd(ADDR_IRQ_STAT, q);
		chk("masked status", 32'h0, {31'h0, q[0]});
		chk("masked irq", 32'h0, {31'h0, irq});
		start(CODE_CH0_RST, 16'h3);
		wait_irq(t);
		rd(ADDR_IRQ_STAT, q);
		chk("status after restart", 32'h1, {31'h0, q[0]});
		$display("t_mask done");
	endtask

	task automatic t_normal();
		start(CODE_CH1_RST, 16'd50);
		idle(200);
		start(CODE_CH1_NORM, 16'd60);
		rd_code(CODE_CH1_RST, q);
		chk("normal start keeps count", 32'h1, {31'h0, q >= 19 && q < 50});
		// separate clear command pins the phase of a normally started channel
		wr(ADDR_CLRCNT, {24'h0, CODE_CH1_NORM});
		rd_code(CODE_CH1_RST, q);
		chk("clear command count", 32'h1, {31'h0, q <= 1});
		start(CODE_CH0_NORM, 16'd4);
		rd_code(CODE_CH1_NORM, q);
		chk("ch1 interval", 32'd60, q);
		rd_code(CODE_CH0_NORM, q);
		chk("ch0 interval", 32'd4, q);
		start(CODE_CH1_RST, 16'd60);
		rd_code(CODE_CH1_RST, q);
		chk("reset start clears", 32'h1, {31'h0, q <= 1});
		$display("t_normal done");
	endtask

	task automatic t_range();
		logic [15:0] vals[4] = '{16'd1, 16'd2, 16'd9999, 16'd10000};
		logic bad[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_IRQ_CLR, 32'h4);
			start(CODE_CH1_NORM, vals[i]);
			rd(ADDR_IRQ_STAT, q);
			chk("range refusal", {31'h0, bad[i]}, {31'h0, q[2]});
		end
		rd_code(CODE_CH1_NORM, q);
		chk("refused not loaded", {16'h0, INTV_MAX_0P1MS}, q);
		// refusal bit drives the line only while enabled
		wr(ADDR_IRQ_EN, 32'h4);
		idle(2);
		chk("enabled irq", 32'h1, {31'h0, irq});
		wr(ADDR_IRQ_EN, 32'h0);
		idle(2);
		chk("disabled irq", 32'h0, {31'h0, irq});
		wr(ADDR_IRQ_CLR, 32'h4);
		rd(ADDR_IRQ_STAT, q);
		chk("cleared status", 32'h0, {31'h0, q[2]});
		$display("t_range done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset();
		t_units();
		t_period();
		t_mask();
		t_normal();
		t_range();
		end_sim();
	end
endmodule
